//--- verilog/ssr_status_readback.sv
// serial status readback side of the 16-bit command/status link
`timescale 1ns/1ps
// Behaviour
// - chip select low loads, then MSB-first shift
// - bits past sixteen echo received bits
// - accept only nonzero multiples of sixteen bits
// - release tri-states output, fault capture resumes
// - invalid message leaves settings and selection untouched
// - readback selection persists until next select
// - upper select bits choose reported output
// - top bit echoes previous watchdog toggle
// - bits 14,13 report undervoltage, overvoltage
// - bits 12..8 echo readback select address
// - bits 7..4 carry per-output fault summaries
// - code 000 returns selected output fault flags
// - address 00001 returns software on bits
// - address 01001 returns sense enable bits
// - code 010 returns trip level settings
// - code 011 returns disable and blanking settings
// - code 100 returns direct input settings
// - address 00101 returns supply fault settings
// - fault pin shows faults, latched until off
// - output select 00..11 maps outputs 0..3
module ssr_status_readback
    import ssr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // serial link pins and fault indicator pin
    input  wire logic        chipSelN,
    input  wire logic        spiClk,
    input  wire logic        serialIn,
    output logic             serialOut,
    output logic             serialOutOeN,
    output logic             faultIndicatorN,
    // status from the rest of the chip (core_clk domain)
    input  wire logic [15:0] outputFaultFlags,
    input  wire logic        undervoltageFlag,
    input  wire logic        overvoltageFlag,
    input  wire logic        watchdogExpired,
    input  wire logic        watchdogActive,
    input  wire logic [1:0]  fallbackOutputState,
    // device pins read back
    input  wire logic        wakePin,
    input  wire logic [3:0]  directInPins,
    // accepted message and stored settings
    output logic             wordStrobe,
    output logic [15:0]      wordData,
    output logic             watchdogToggleEcho,
    output logic [3:0]       softwareOnBits,
    output logic [3:0]       supplyFaultConfig,
    output logic [3:0]       senseEnableLow,
    output logic [15:0]      overcurrentLevelConfig,
    output logic [15:0]      overcurrentTimingConfig,
    output logic [15:0]      directInputConfig,
    output logic [3:0]       watchdogConfig
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // one nibble out of a packed set of four
    function automatic logic [3:0] pickNibble(input logic [15:0] v, input logic [1:0] s);
        logic [3:0] r;
        r = 4'h0;
        case (s)
            2'b00:   r = v[3:0];
            2'b01:   r = v[7:4];
            2'b10:   r = v[11:8];
            2'b11:   r = v[15:12];
            default: r = 4'h0;
        endcase
        return r;
    endfunction : pickNibble

    // replace one nibble of a packed set of four
    function automatic logic [15:0] putNibble(input logic [15:0] v, input logic [1:0] s,
                                              input logic [3:0] n);
        logic [15:0] r;
        r = v;
        case (s)
            2'b00:   r[3:0]   = n;
            2'b01:   r[7:4]   = n;
            2'b10:   r[11:8]  = n;
            2'b11:   r[15:12] = n;
            default: r = v;
        endcase
        return r;
    endfunction : putNibble

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] csSync_r;
    logic [2:0] sckSync_r;
    logic [1:0] siSync_r;
    logic [1:0] wakeSync_r;
    logic [3:0] dinMeta_r;
    logic [3:0] dinSync_r;
    logic [3:0] dinPrev_r;

    // two flops per pin, third stage only for edge finding
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            csSync_r   <= 3'h7;
            sckSync_r  <= 3'h0;
            siSync_r   <= 2'h0;
            wakeSync_r <= 2'h0;
            dinMeta_r  <= 4'h0;
            dinSync_r  <= 4'h0;
            dinPrev_r  <= 4'h0;
        end else begin
            csSync_r   <= {csSync_r[1:0], chipSelN};
            sckSync_r  <= {sckSync_r[1:0], spiClk};
            siSync_r   <= {siSync_r[0], serialIn};
            wakeSync_r <= {wakeSync_r[0], wakePin};
            dinMeta_r  <= directInPins;
            dinSync_r  <= dinMeta_r;
            dinPrev_r  <= dinSync_r;
        end
    end

    logic csFall;
    logic csRise;
    logic sckRise;
    logic sckFall;
    logic siBit;
    logic wakeLvl;
    logic [3:0] dinFall;

    // edge detection on the second and third stages
    assign csFall  = csSync_r[2] & ~csSync_r[1];
    assign csRise  = ~csSync_r[2] & csSync_r[1];
    assign sckRise = ~sckSync_r[2] & sckSync_r[1];
    assign sckFall = sckSync_r[2] & ~sckSync_r[1];
    assign siBit   = siSync_r[1];
    assign wakeLvl = wakeSync_r[1];
    assign dinFall = dinPrev_r & ~dinSync_r;

    // ------------------------------------------------------------
    // link state
    // ------------------------------------------------------------
    ssr_link_t linkState_r;
    ssr_link_t linkState_nxt;

    // frame opens on select fall, closes on select rise
    always_comb begin
        linkState_nxt = linkState_r;
        case (linkState_r)
            SSR_IDLE:  if (csFall) linkState_nxt = SSR_FRAME;
            SSR_FRAME: if (csRise) linkState_nxt = SSR_IDLE;
            default:   linkState_nxt = SSR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            linkState_r <= SSR_IDLE;
        end else begin
            linkState_r <= linkState_nxt;
        end
    end

    logic inFrame;
    logic frameEnd;
    logic frameStart;
    assign inFrame    = (linkState_r == SSR_FRAME);
    assign frameStart = (linkState_r == SSR_IDLE) && csFall;
    assign frameEnd   = inFrame && csRise;

    // ------------------------------------------------------------
    // bit counting and length check
    // ------------------------------------------------------------
    logic [3:0] bitCnt_r;
    logic       gotBits_r;
    logic       lenValid;

    // count modulo sixteen, remember that any bit arrived
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bitCnt_r  <= SSR_RST_CNT;
            gotBits_r <= 1'b0;
        end else if (frameStart) begin
            bitCnt_r  <= SSR_RST_CNT;
            gotBits_r <= 1'b0;
        end else if (inFrame && sckRise) begin
            bitCnt_r  <= bitCnt_r + 4'h1;
            gotBits_r <= 1'b1;
        end
    end

    assign lenValid = gotBits_r && (bitCnt_r == SSR_RST_CNT);

    logic accept;
    assign accept = frameEnd && lenValid;

    // ------------------------------------------------------------
    // stored readback selection and watchdog echo
    // ------------------------------------------------------------
    logic [15:0] shiftReg_r;
    logic [4:0]  readSel_r;
    logic        wdEcho_r;
    logic        firstWord_r;
    logic [4:0]  msgAddr;
    logic [3:0]  msgData;
    logic [1:0]  msgOut;

    assign msgAddr = shiftReg_r[SSR_ADDR_HI:SSR_ADDR_LO];
    assign msgData = shiftReg_r[3:0];
    assign msgOut  = shiftReg_r[SSR_ADDR_HI:SSR_ADDR_HI-1];

    // selection kept until the next select write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            readSel_r <= SSR_RST_SEL;
            wdEcho_r  <= 1'b0;
        end else if (accept) begin
            // keep toggle bit of last word
            wdEcho_r <= shiftReg_r[SSR_WD_BIT];
            if (msgAddr == SSR_A_SELECT) begin
                readSel_r <= shiftReg_r[SSR_SEL_HI:SSR_SEL_LO];
            end
        end
    end

    // all-zero status in the first frame after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            firstWord_r <= 1'b1;
        end else if (frameStart) begin
            firstWord_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // programmable settings written by accepted messages
    // ------------------------------------------------------------
    // latch data into addressed register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            softwareOnBits          <= SSR_RST_NIB;
            supplyFaultConfig       <= SSR_RST_NIB;
            senseEnableLow          <= SSR_RST_NIB;
            watchdogConfig          <= SSR_RST_NIB;
            overcurrentLevelConfig  <= SSR_RST_WORD;
            overcurrentTimingConfig <= SSR_RST_WORD;
            directInputConfig       <= SSR_RST_WORD;
        end else if (accept) begin
            case (msgAddr)
                SSR_A_ON_CMD:   softwareOnBits    <= msgData;
                SSR_A_SUPPLY:   supplyFaultConfig <= msgData;
                SSR_A_SENSE:    senseEnableLow    <= msgData;
                SSR_A_WATCHDOG: watchdogConfig    <= msgData;
                default: begin
                    // per-output write steered by top bits
                    case (msgAddr[2:0])
                        SSR_C_LEVEL: overcurrentLevelConfig <=
                            putNibble(overcurrentLevelConfig, msgOut, msgData);
                        SSR_C_TIMING: overcurrentTimingConfig <=
                            putNibble(overcurrentTimingConfig, msgOut, msgData);
                        SSR_C_DIRECT: directInputConfig <=
                            putNibble(directInputConfig, msgOut, msgData);
                        default: ;
                    endcase
                end
            endcase
        end
    end

    // accepted word handed on as a one-cycle strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wordStrobe         <= 1'b0;
            wordData           <= SSR_RST_WORD;
            watchdogToggleEcho <= 1'b0;
        end else begin
            wordStrobe <= accept;
            if (accept) begin
                wordData           <= shiftReg_r;
                watchdogToggleEcho <= shiftReg_r[SSR_WD_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // fault capture, supply flags
    // ------------------------------------------------------------
    logic [15:0] faultHold_r;
    logic        uvSeen_r;
    logic        ovSeen_r;

    // fault status follows chip only between frames
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            faultHold_r <= SSR_RST_WORD;
        end else if (!inFrame && !csFall) begin
            faultHold_r <= outputFaultFlags;
        end
    end

    // sticky supply flags, cleared at every frame start; set wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uvSeen_r <= 1'b0;
            ovSeen_r <= 1'b0;
        end else begin
            uvSeen_r <= undervoltageFlag | (uvSeen_r & ~frameStart);
            ovSeen_r <= overvoltageFlag | (ovSeen_r & ~frameStart);
        end
    end

    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    logic [3:0]  faultSum;
    logic [3:0]  lowNib;
    logic [15:0] statusWord;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            faultSum[i] = |faultHold_r[4*i +: 4];
        end
    end

    // low nibble chosen by the stored selection
    always_comb begin
        lowNib = 4'h0;
        case (readSel_r)
            SSR_A_ON_CMD:   lowNib = softwareOnBits;
            SSR_A_SENSE:    lowNib = senseEnableLow;
            SSR_A_SUPPLY:   lowNib = supplyFaultConfig;
            SSR_A_WATCHDOG: lowNib = {1'b0, watchdogExpired, watchdogConfig[1:0]};
            SSR_A_INPUTS:   lowNib = dinSync_r;
            SSR_A_FAILSAFE: lowNib = {fallbackOutputState, watchdogActive, wakeLvl};
            SSR_A_OT_HIGH:  lowNib = {watchdogConfig[3:2], 2'b00};
            default: begin
                // upper select bits pick the output
                case (readSel_r[2:0])
                    SSR_C_FAULT:  lowNib = pickNibble(faultHold_r, readSel_r[4:3]);
                    SSR_C_LEVEL:  lowNib = pickNibble(overcurrentLevelConfig, readSel_r[4:3]);
                    SSR_C_TIMING: lowNib = pickNibble(overcurrentTimingConfig, readSel_r[4:3]);
                    SSR_C_DIRECT: lowNib = pickNibble(directInputConfig, readSel_r[4:3]);
                    default:      lowNib = 4'h0;
                endcase
            end
        endcase
    end

    assign statusWord = {wdEcho_r, uvSeen_r, ovSeen_r, readSel_r, faultSum, lowNib};

    // ------------------------------------------------------------
    // shift register and serial output
    // ------------------------------------------------------------
    // load on select fall, shift on clock rise
    // received bits enter low end, emerge after sixteen
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shiftReg_r <= SSR_RST_WORD;
        end else if (frameStart) begin
            shiftReg_r <= firstWord_r ? SSR_RST_WORD : statusWord;
        end else if (inFrame && sckRise) begin
            shiftReg_r <= {shiftReg_r[14:0], siBit};
        end
    end

    // output bit changes on falling clock, driven only in frame
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serialOut    <= 1'b0;
            serialOutOeN <= 1'b1;
        end else if (frameStart) begin
            serialOut    <= firstWord_r ? 1'b0 : statusWord[SSR_WORD_W-1];
            serialOutOeN <= 1'b0;
        end else if (frameEnd) begin
            // release the output at frame end
            serialOutOeN <= 1'b1;
        end else if (inFrame && sckFall) begin
            serialOut <= shiftReg_r[SSR_WORD_W-1];
        end
    end

    // ------------------------------------------------------------
    // fault indicator pin
    // ------------------------------------------------------------
    logic [3:0] faultLatch_r;
    logic [3:0] offCmd;

    // switch-off by accepted on-command write or falling input pin
    always_comb begin
        offCmd = dinFall;
        if (accept && (msgAddr == SSR_A_ON_CMD)) begin
            offCmd = offCmd | ~msgData;
        end
    end

    // latched per output until switched off, set wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            faultLatch_r <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                faultLatch_r[i] <= (|outputFaultFlags[4*i +: 4]) |
                                   (faultLatch_r[i] & ~offCmd[i]);
            end
        end
    end

    // pin low while any fault is present or latched
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            faultIndicatorN <= 1'b1;
        end else begin
            faultIndicatorN <= ~((|outputFaultFlags) | (|faultLatch_r));
        end
    end

endmodule : ssr_status_readback

//--- include/ssr_pkg.sv
// shared constants and types for the serial status readback block
package ssr_pkg;

    // ------------------------------------------------------------
    // message geometry
    // ------------------------------------------------------------
    localparam int          SSR_WORD_W      = 16;
    localparam int          SSR_CNT_W       = 4;
    localparam int          SSR_WD_BIT      = 15;
    localparam int          SSR_UV_BIT      = 14;
    localparam int          SSR_OV_BIT      = 13;
    localparam int          SSR_ADDR_HI     = 12;
    localparam int          SSR_ADDR_LO     = 8;
    localparam int          SSR_SUM_HI      = 7;
    localparam int          SSR_SUM_LO      = 4;
    localparam int          SSR_SEL_HI      = 4;
    localparam int          SSR_SEL_LO      = 0;

    // ------------------------------------------------------------
    // register addresses (five-bit address field of a message)
    // ------------------------------------------------------------
    localparam logic [4:0]  SSR_A_SELECT    = 5'h00;
    localparam logic [4:0]  SSR_A_ON_CMD    = 5'h01;
    localparam logic [4:0]  SSR_A_SUPPLY    = 5'h05;
    localparam logic [4:0]  SSR_A_FAILSAFE  = 5'h06;
    localparam logic [4:0]  SSR_A_SENSE     = 5'h09;
    localparam logic [4:0]  SSR_A_WATCHDOG  = 5'h0D;
    localparam logic [4:0]  SSR_A_INPUTS    = 5'h0E;
    localparam logic [4:0]  SSR_A_OT_HIGH   = 5'h0F;

    // low three address bits of the per-output registers
    localparam logic [2:0]  SSR_C_FAULT     = 3'h0;
    localparam logic [2:0]  SSR_C_LEVEL     = 3'h2;
    localparam logic [2:0]  SSR_C_TIMING    = 3'h3;
    localparam logic [2:0]  SSR_C_DIRECT    = 3'h4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  SSR_RST_NIB     = 4'h0;
    localparam logic [15:0] SSR_RST_WORD    = 16'h0000;
    localparam logic [4:0]  SSR_RST_SEL     = 5'h00;
    localparam logic [3:0]  SSR_RST_CNT     = 4'h0;

    // ------------------------------------------------------------
    // link state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSR_IDLE  = 2'b01,
        SSR_FRAME = 2'b10
    } ssr_link_t;

endpackage : ssr_pkg

//--- verification/ssr_status_readback_sva.sv
// concurrent checks on the status readback ports
`timescale 1ns/1ps
module ssr_status_readback_sva
    import ssr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        chipSelN,
    input wire logic        serialOutOeN,
    input wire logic        faultIndicatorN,
    input wire logic [15:0] outputFaultFlags,
    input wire logic        wordStrobe,
    input wire logic [15:0] wordData,
    input wire logic        watchdogToggleEcho,
    input wire logic [3:0]  softwareOnBits,
    input wire logic [15:0] overcurrentLevelConfig
);
    // one clock domain for every check
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_OE_DRIVE: assert property ($fell(chipSelN) |-> ##[1:6] !serialOutOeN)
        else $error("output not driven after select");
    AST_OE_RELEASE: assert property (chipSelN [*6] |-> serialOutOeN)
        else $error("output driven while deselected");
    AST_STROBE_PULSE: assert property (wordStrobe |=> !wordStrobe)
        else $error("strobe longer than one cycle");
    AST_STROBE_CAUSE: assert property (wordStrobe |-> chipSelN && $past(chipSelN, 3))
        else $error("strobe without frame end");
    AST_TOGGLE_ECHO: assert property (wordStrobe |=> watchdogToggleEcho == wordData[15])
        else $error("toggle echo wrong");
    AST_ON_WRITE: assert property (wordStrobe && wordData[12:8] == SSR_A_ON_CMD
        |=> softwareOnBits == wordData[3:0])
        else $error("on bits not written");
    AST_LEVEL_WRITE: assert property (wordStrobe && wordData[10:8] == SSR_C_LEVEL
        |=> overcurrentLevelConfig[{wordData[12:11], 2'b00} +: 4] == wordData[3:0])
        else $error("level nibble wrong");
    AST_QUIET_CONFIG: assert property ($changed(softwareOnBits) |-> ##[0:2] wordStrobe)
        else $error("setting changed without message");
    AST_FAULT_PIN: assert property (|outputFaultFlags |-> ##[0:3] !faultIndicatorN)
        else $error("fault pin not low");
endmodule : ssr_status_readback_sva

bind ssr_status_readback ssr_status_readback_sva u_sva (
    .core_clk(core_clk), .nrst(nrst), .chipSelN(chipSelN),
    .serialOutOeN(serialOutOeN), .faultIndicatorN(faultIndicatorN),
    .outputFaultFlags(outputFaultFlags), .wordStrobe(wordStrobe),
    .wordData(wordData), .watchdogToggleEcho(watchdogToggleEcho),
    .softwareOnBits(softwareOnBits), .overcurrentLevelConfig(overcurrentLevelConfig)
);

//--- verification/ssr_spi_host.sv
// link master model driving the serial pins
`timescale 1ns/1ps
module ssr_spi_host (
    output logic      chipSelN,
    output logic      spiClk,
    output logic      serialIn,
    input  wire logic serialOut
);
    // idle levels, link clock stands still
    initial begin
        chipSelN = 1'b1;
        spiClk   = 1'b0;
        serialIn = 1'b0;
    end

    // one frame of n bits, msb first, 160 ns link period
    task automatic xfer(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        #7 chipSelN = 1'b0;
        #200;
        for (int k = 0; k < n; k++) begin
            serialIn = din[n-1-k];
            #80 spiClk = 1'b1;
            #40 dout = {dout[30:0], serialOut};
            #40 spiClk = 1'b0;
        end
        #200 chipSelN = 1'b1;
        serialIn = ~serialIn; // toggled line, no stale value
        #200;
    endtask : xfer
endmodule : ssr_spi_host

//--- verification/test_ssr_status_readback.sv
// self-checking bench for the status readback block
`timescale 1ns/1ps
module test_ssr_status_readback;
    import ssr_pkg::*;
    logic        core_clk, nrst, chipSelN, spiClk, serialIn, serialOut, serialOutOeN;
    logic        faultIndicatorN, undervoltageFlag, overvoltageFlag, watchdogExpired;
    logic        watchdogActive, wakePin, wordStrobe, watchdogToggleEcho;
    logic [1:0]  fallbackOutputState;
    logic [3:0]  directInPins, softwareOnBits, supplyFaultConfig, senseEnableLow;
    logic [3:0]  watchdogConfig;
    logic [15:0] outputFaultFlags, wordData, overcurrentLevelConfig;
    logic [15:0] overcurrentTimingConfig, directInputConfig;
    logic [31:0] got;
    logic [59:0] r;
    int          n_fail, checks_done, cycles;

    ssr_spi_host u_host (.chipSelN(chipSelN), .spiClk(spiClk), .serialIn(serialIn),
        .serialOut(serialOut));

    ssr_status_readback u_dut (
        .core_clk(core_clk), .nrst(nrst), .chipSelN(chipSelN), .spiClk(spiClk),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN),
        .faultIndicatorN(faultIndicatorN), .outputFaultFlags(outputFaultFlags),
        .undervoltageFlag(undervoltageFlag), .overvoltageFlag(overvoltageFlag),
        .watchdogExpired(watchdogExpired), .watchdogActive(watchdogActive),
        .fallbackOutputState(fallbackOutputState), .wakePin(wakePin),
        .directInPins(directInPins), .wordStrobe(wordStrobe), .wordData(wordData),
        .watchdogToggleEcho(watchdogToggleEcho), .softwareOnBits(softwareOnBits),
        .supplyFaultConfig(supplyFaultConfig), .senseEnableLow(senseEnableLow),
        .overcurrentLevelConfig(overcurrentLevelConfig),
        .overcurrentTimingConfig(overcurrentTimingConfig),
        .directInputConfig(directInputConfig), .watchdogConfig(watchdogConfig));

    // rows: written word, select word, faults, pins, expected low nibble
    localparam logic [59:0] ROWS [11] = '{
        {16'h0105, 16'h8001, 16'h0000, 8'h00, 4'h5},
        {16'h090A, 16'h0009, 16'h0000, 8'h00, 4'hA},
        {16'h0503, 16'h8005, 16'h0000, 8'h00, 4'h3},
        {16'h1207, 16'h0012, 16'h0000, 8'h00, 4'h7},
        {16'h0B0C, 16'h000B, 16'h0000, 8'h00, 4'hC},
        {16'h1C09, 16'h801C, 16'h0000, 8'h00, 4'h9},
        {16'h0600, 16'h0008, 16'h0050, 8'h00, 4'h5},
        {16'h0D03, 16'h000D, 16'h0000, 8'h00, 4'h3},
        {16'h0600, 16'h000E, 16'h0000, 8'h0A, 4'hA},
        {16'h0600, 16'h0006, 16'h0000, 8'hA0, 4'hA},
        {16'h0D0C, 16'h000F, 16'h0000, 8'h00, 4'hC}};

    // per-output fault summary
    function automatic logic [3:0] sum4(input logic [15:0] f);
        sum4 = {|f[15:12], |f[11:8], |f[7:4], |f[3:0]};
    endfunction : sum4

    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // verdict and end of run
    task test_done();
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    // main sequence
    initial begin
        {nrst, undervoltageFlag, overvoltageFlag, watchdogExpired} = 4'h0;
        {fallbackOutputState, watchdogActive, wakePin, directInPins} = 8'h00;
        outputFaultFlags = 16'h0;
        {n_fail, checks_done, cycles} = '0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        u_host.xfer(16, 32'h0600, got);
        chk(got, 32'h0);
        for (int i = 0; i < 11; i++) begin
            r = ROWS[i];
            @(posedge core_clk);
            outputFaultFlags <= r[27:12];
            {fallbackOutputState, watchdogActive, wakePin, directInPins} <= r[11:4];
            u_host.xfer(16, {16'h0, r[59:44]}, got);
            u_host.xfer(16, {16'h0, r[43:28]}, got);
            u_host.xfer(16, 32'h0600, got);
            chk(got, {r[43], 2'b00, r[32:28], sum4(r[27:12]), r[3:0]});
            u_host.xfer(16, 32'h0600, got);
            chk(got, {1'b0, 2'b00, r[32:28], sum4(r[27:12]), r[3:0]});
        end
        // frames of invalid length leave status untouched
        for (int n = 0; n <= 20; n += 4) begin
            if (n % 16 != 0 || n == 0) begin
                u_host.xfer(n, 32'h00080009, got);
                u_host.xfer(16, 32'h0600, got);
                chk(got, 32'h0F0C);
            end
        end
        // two words in one frame, the second bits echo the first
        u_host.xfer(32, 32'h86F00600, got);
        chk(got, 32'h0F0C86F0);
        // supply flags sticky until reported
        @(posedge core_clk);
        {undervoltageFlag, overvoltageFlag} <= 2'b11;
        repeat (5) @(posedge core_clk);
        {undervoltageFlag, overvoltageFlag} <= 2'b00;
        u_host.xfer(16, 32'h0600, got);
        chk(got, 32'h6F0C);
        u_host.xfer(16, 32'h0600, got);
        chk(got, 32'h0F0C);
        // brief fault latches the pin until an off command
        @(posedge core_clk);
        outputFaultFlags <= 16'h0100;
        @(posedge core_clk);
        outputFaultFlags <= 16'h0000;
        repeat (3) @(posedge core_clk);
        chk(faultIndicatorN, 32'h0);
        u_host.xfer(16, 32'h0100, got);
        repeat (2) @(posedge core_clk);
        chk(faultIndicatorN, 32'h1);
        // reset in mid-run clears status
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk({serialOutOeN, wordData}, 32'h10000);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        u_host.xfer(16, 32'h0600, got);
        chk(got, 32'h0);
        test_done();
    end
endmodule : test_ssr_status_readback
